/* File: adc_model.sv */
/*
 * Behavioural converter answering each start pulse with a done pulse.
 * Assumes start is a one-cycle pulse on the sequencer clock.
 */
module adc_model
(
   // Clock and converter handshake
   input  wire logic i_mclk,
   input  wire logic i_conv_start,
   output logic      o_adc_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] cnt_r;
   initial
   begin
      cnt_r = 3'h0;
      o_adc_done = 1'b0;
   end
   // Fixed latency keeps the channel order deterministic
   always @(posedge i_mclk)
   begin
      o_adc_done <= (cnt_r == 3'h1);
      if (i_conv_start)
         cnt_r <= 3'h4;
      else if (cnt_r != 3'h0)
         cnt_r <= cnt_r - 3'h1;
   end
endmodule

/* File: pin_sync_edge.sv */
/*
 * Two-stage synchroniser with edge detection for one asynchronous pin.
 * Assumes the pin is slower than half the sampling clock.
 */
module pin_sync_edge
(
   // Clock and reset
   input  wire logic i_mclk,
   input  wire logic i_rst,
   input  wire logic i_ce,
   // Pin and results
   input  wire logic i_pin,
   output logic      o_level,
   output logic      o_rise,
   output logic      o_fall
);
   logic meta_r;
   logic sync_r;
   logic prev_r;
   logic meta_nxt;
   logic sync_nxt;
   logic prev_nxt;

   always_comb
   begin
      meta_nxt = i_pin;
      sync_nxt = meta_r;
      prev_nxt = sync_r;
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end
      else if (i_ce)
      begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         prev_r <= prev_nxt;
      end
   end

   // Only the second and third stages feed logic
   assign o_level = sync_r;
   assign o_rise  = sync_r & ~prev_r;
   assign o_fall  = ~sync_r & prev_r;
endmodule

/* File: test_touch_acquisition_sequencer.sv */
/*
 * Self-checking bench of the touch acquisition sequencer.
 * Assumes short power-up and rate counts; inputs change on the falling edge.
 */
module test_touch_acquisition_sequencer
   import touch_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, rst, cfg_wr, cmd_v, cmd_cv, st_rd, rd_done, touch, aux, adc_done, ce, gated;
   logic [3:0] rate;
   logic alert_o, alert_oe, bias_en, conv_start, data_valid, busy;
   logic [1:0] op_mode, aux_mode;
   logic [4:0] mask;
   logic [15:0] bias_dly;
   logic [2:0] filt, cmd_ch, conv_ch;
   logic [7:0] status;
   logic [2:0] q[$];
   int num_errors = 0;
   int check_count = 0;

   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   touch_acquisition_sequencer #(.POWERUP_CYCLES(8), .RATE_CYCLES(4)) u_touch_acquisition_sequencer (
      .i_mclk(mclk), .i_rst(rst), .i_ce(ce), .i_cfg_write(cfg_wr), .i_op_mode(op_mode),
      .i_rate(rate), .i_chan_mask(mask), .i_bias_settle_delay(bias_dly),
      .i_filter_settle_delay(16'h0001), .i_filt_count(filt), .i_touch_gated_interrupt(gated),
      .i_aux_trigger_mode(aux_mode), .i_cmd_valid(cmd_v), .i_cmd_convert(cmd_cv),
      .i_cmd_chan(cmd_ch), .i_status_read(st_rd), .i_data_read_done(rd_done),
      .i_touch_pin(touch), .i_aux_pin(aux), .i_adc_done(adc_done),
      .o_host_alert_n_o(alert_o), .o_host_alert_n_oe(alert_oe), .o_status(status),
      .o_bias_en(bias_en), .o_conv_start(conv_start), .o_conv_chan(conv_ch),
      .o_data_valid(data_valid), .o_busy(busy));

   adc_model u_adc_model (.i_mclk(mclk), .i_conv_start(conv_start), .o_adc_done(adc_done));

   always @(posedge mclk)
      if (conv_start === 1'b1)
         q.push_back(conv_ch);

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic stop_test();
      if (num_errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic pulse(ref logic s);
      @(negedge mclk) s = 1'b1;
      @(negedge mclk) s = 1'b0;
   endtask

   task automatic cfg(input logic [1:0] m, input logic [1:0] a);
      @(negedge mclk);
      op_mode = m;
      aux_mode = a;
      mask = 5'h15;
      bias_dly = 16'h0002;
      filt = 3'h2;
      pulse(cfg_wr);
   endtask

   task automatic cmd(input logic cv, input logic [2:0] ch);
      cmd_cv = cv;
      cmd_ch = ch;
      pulse(cmd_v);
   endtask

   // Bounded wait for the alert to be pulled low
   task automatic wait_alert();
      int i;
      for (i = 0; i < 400 && alert_oe !== 1'b0; i++)
         @(negedge mclk);
      if (alert_oe !== 1'b0)
      begin
         num_errors++;
         $display("unexpected at %0t: alert timeout got %h expected %h", $time, alert_oe, 1'b0);
         stop_test();
      end
   endtask

   // Sequence with mask 10101 and two conversions per channel
   task automatic chk_seq();
      chk(q.size(), 8'h06);
      for (int i = 0; i < 6 && i < q.size(); i++)
         chk(q[i], 8'(4 - 2 * (i / 2)));
      q.delete();
   endtask

   task automatic release_done();
      pulse(rd_done);
      chk(status, 8'h00);
      chk(alert_oe, 8'h01);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      {rst, cfg_wr, cmd_v, cmd_cv, st_rd, rd_done, touch, aux} = 8'hFF;
      {cfg_wr, cmd_v, cmd_cv, st_rd, rd_done, touch, aux} = 7'h00;
      {op_mode, aux_mode, mask, bias_dly, filt, cmd_ch, rate, gated} = '0;
      ce = 1'b1;
      cyc(20);
      chk(alert_oe, 8'h00);
      chk(status, 8'h20);
      rst = 1'b0;
      // Enable low must freeze the power-up count
      ce = 1'b0;
      cyc(5);
      chk(alert_oe, 8'h00);
      ce = 1'b1;
      cyc(7);
      chk(alert_oe, 8'h00);
      cyc(2);
      chk(alert_oe, 8'h01);
      chk(alert_o, 8'h00);
      pulse(st_rd);
      cmd(1'b1, 3'h2);
      wait_alert();
      chk(status, 8'h80);
      chk(q.size(), 8'h01);
      chk(q.pop_front(), 8'h02);
      cmd(1'b1, 3'h3);
      cyc(20);
      chk(q.size(), 8'h00);
      release_done();
      cmd(1'b0, 3'h1);
      cyc(10);
      chk(bias_en, 8'h01);
      chk(conv_ch, 8'h01);
      chk(q.size(), 8'h00);
      chk(alert_oe, 8'h01);
      cfg(2'h0, 2'h0);
      cmd(1'b1, 3'h7);
      wait_alert();
      chk_seq();
      release_done();
      // Each aux trigger mode 1 to 3 sees one rise and one fall 400 ns apart
      for (int m = 1; m < 4; m++)
      begin
         cfg(2'h0, 2'(m));
         aux = 1'b1;
         cyc(8);
         aux = 1'b0;
         wait_alert();
         chk_seq();
         release_done();
      end
      cfg(2'h1, 2'h0);
      touch = 1'b1;
      wait_alert();
      chk(status, 8'h40);
      touch = 1'b0;
      pulse(st_rd);
      chk(status, 8'h00);
      chk(alert_oe, 8'h01);
      cfg(2'h2, 2'h0);
      cyc(20);
      chk(busy, 8'h00);
      touch = 1'b1;
      wait_alert();
      touch = 1'b0;
      chk(status[7], 8'h01);
      chk_seq();
      release_done();
      // Automatic runs: ungated twice, then gated by touch
      rate = 4'h1;
      cfg(2'h0, 2'h0);
      wait_alert();
      chk(data_valid, 8'h00);
      chk_seq();
      release_done();
      wait_alert();
      chk_seq();
      gated = 1'b1;
      cfg(2'h0, 2'h0);
      release_done();
      cyc(20);
      chk(busy, 8'h00);
      chk(alert_oe, 8'h01);
      touch = 1'b1;
      wait_alert();
      touch = 1'b0;
      chk(data_valid, 8'h01);
      chk_seq();
      release_done();
      stop_test();
   end
endmodule

/* File: touch_acquisition_sequencer.sv */
/*
 * Acquisition sequencer and alert logic of a resistive touch controller.
 * Assumes the serial front end decodes host traffic into one-cycle strobes
 * on this clock; touch and aux pins are asynchronous.
 */
// Functional notes
// - Automatic cycle: touch detect, bias settle, then every selected channel converted.
// - Touch-detect-only mode: touch sets touch flag bit 6 and asserts alert.
// - Touch-detect-only mode: status read clears touch flag and releases alert.
// - Touch-triggered mode idles until touch, then converts and alerts.
// - Without any configuration write since reset, manual mode applies.
// - Single conversion takes channel from 3-bit command channel field.
// - Sequence code converts mask-enabled channels from most to least significant.
// - Mask bit one converts the channel, zero skips to next enabled one.
// - Averaging runs up to 7 conversions per channel with filter settle between.
// - Aux trigger mode nonzero: selected aux edge starts conversions.
// - Aux edge starts bias settling first; acquisition follows after it.
// - Alert held low during power-up and reset, released afterwards.
// - Conversion completion sets done flag bit 7 and alert together.
// - Host reading all data clears done flag and releases alert together.
// - Alert is open drain: only driven low, released to pull-up.
// - No new conversion starts while alert is asserted.
// - Automatic mode with gating set alerts only on touch; else marks untouched invalid.
// - Convert command biases, waits bias settle, converts; select only biases.
// - Sample interval zero means manual, nonzero automatic; host exits touch modes.
module touch_acquisition_sequencer
   import touch_seq_pkg::*;
#(
   parameter int POWERUP_CYCLES = POWERUP_CYC,
   parameter int RATE_CYCLES    = RATE_UNIT_CYC
)
(
   // Clock, reset, enable
   input  wire logic                i_mclk,
   input  wire logic                i_rst,
   input  wire logic                i_ce,
   // Configuration, captured on i_cfg_write
   input  wire logic                i_cfg_write,
   input  wire logic [1:0]          i_op_mode,
   input  wire logic [RATE_W-1:0]   i_rate,
   input  wire logic [NUM_CH-1:0]   i_chan_mask,
   input  wire logic [DLY_W-1:0]    i_bias_settle_delay,
   input  wire logic [DLY_W-1:0]    i_filter_settle_delay,
   input  wire logic [FILT_W-1:0]   i_filt_count,
   input  wire logic                i_touch_gated_interrupt,
   input  wire logic [1:0]          i_aux_trigger_mode,
   // Manual commands
   input  wire logic                i_cmd_valid,
   input  wire logic                i_cmd_convert,
   input  wire logic [CHAN_W-1:0]   i_cmd_chan,
   // Host read strobes
   input  wire logic                i_status_read,
   input  wire logic                i_data_read_done,
   // Analog side and pins
   input  wire logic                i_touch_pin,
   input  wire logic                i_aux_pin,
   input  wire logic                i_adc_done,
   // Alert pin, open drain
   output logic                     o_host_alert_n_o,
   output logic                     o_host_alert_n_oe,
   // Status and converter control
   output logic [7:0]               o_status,
   output logic                     o_bias_en,
   output logic                     o_conv_start,
   output logic [CHAN_W-1:0]        o_conv_chan,
   output logic                     o_data_valid,
   output logic                     o_busy
);
   localparam int PWR_W  = $clog2(POWERUP_CYCLES + 1);
   localparam int RCNT_W = $clog2(RATE_CYCLES * 15 + 1);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic touch_lvl;
   logic touch_rise;
   logic aux_rise;
   logic aux_fall;

   pin_sync_edge u_touch_sync (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_ce    (i_ce),
      .i_pin   (i_touch_pin),
      .o_level (touch_lvl),
      .o_rise  (touch_rise),
      .o_fall  ()
   );

   pin_sync_edge u_aux_sync (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_ce    (i_ce),
      .i_pin   (i_aux_pin),
      .o_level (),
      .o_rise  (aux_rise),
      .o_fall  (aux_fall)
   );

   // ----------------------------------------------------------------
   // Highest enabled channel strictly below a bound; bit 3 = found
   // ----------------------------------------------------------------
   function automatic logic [3:0] pick_chan(input logic [NUM_CH-1:0] m, input int below);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 0; i < NUM_CH; i++)
         if (m[i] && i < below)
            r = {1'b1, CHAN_W'(i)};
      return r;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   seq_state_e         state_r,    state_nxt;
   op_mode_e           mode_r,     mode_nxt;
   aux_mode_e          aux_r,      aux_nxt;
   logic [RATE_W-1:0]  rate_r,     rate_nxt;
   logic [NUM_CH-1:0]  mask_r,     mask_nxt;
   logic [DLY_W-1:0]   bdly_r,     bdly_nxt;
   logic [DLY_W-1:0]   fdly_r,     fdly_nxt;
   logic [FILT_W-1:0]  filt_n_r,   filt_n_nxt;
   logic               gated_r,    gated_nxt;
   logic               cfg_seen_r, cfg_seen_nxt;
   logic [CHAN_W-1:0]  cmd_chan_r, cmd_chan_nxt;
   logic [CHAN_W-1:0]  chan_r,     chan_nxt;
   logic               seq_r,      seq_nxt;
   logic [DLY_W-1:0]   dly_r,      dly_nxt;
   logic [FILT_W-1:0]  filt_cnt_r, filt_cnt_nxt;
   logic [RCNT_W-1:0]  rate_cnt_r, rate_cnt_nxt;
   logic [PWR_W-1:0]   pwr_cnt_r,  pwr_cnt_nxt;
   logic               touched_r,  touched_nxt;
   logic               conv_fl_r,  conv_fl_nxt;
   logic               touch_fl_r, touch_fl_nxt;
   logic               rst_evt_r,  rst_evt_nxt;
   logic               bias_r,     bias_nxt;
   logic               start_r,    start_nxt;
   logic               valid_r,    valid_nxt;
   logic               oe_r,       oe_nxt;
   logic               go;
   logic               go_seq;
   logic [CHAN_W-1:0]  go_chan;
   logic               done_evt;
   logic               aux_hit;
   logic [3:0]         pick;
   logic [FILT_W-1:0]  filt_eff;
   logic               auto_mode;

   assign auto_mode = (mode_r == MODE_MANUAL_AUTO) && (rate_r != '0);
   assign filt_eff  = (filt_n_r == '0) ? FILT_W'(1) : filt_n_r;
   assign aux_hit   = (aux_r == AUX_RISE && aux_rise) || (aux_r == AUX_FALL && aux_fall)
                    || (aux_r == AUX_BOTH && (aux_rise || aux_fall));

   always_comb
   begin
      state_nxt    = state_r;
      mode_nxt     = mode_r;
      aux_nxt      = aux_r;
      rate_nxt     = rate_r;
      mask_nxt     = mask_r;
      bdly_nxt     = bdly_r;
      fdly_nxt     = fdly_r;
      filt_n_nxt   = filt_n_r;
      gated_nxt    = gated_r;
      cfg_seen_nxt = cfg_seen_r;
      cmd_chan_nxt = cmd_chan_r;
      chan_nxt     = chan_r;
      seq_nxt      = seq_r;
      dly_nxt      = dly_r;
      filt_cnt_nxt = filt_cnt_r;
      rate_cnt_nxt = rate_cnt_r;
      pwr_cnt_nxt  = pwr_cnt_r;
      touched_nxt  = touched_r;
      conv_fl_nxt  = conv_fl_r;
      touch_fl_nxt = touch_fl_r;
      rst_evt_nxt  = rst_evt_r;
      bias_nxt     = bias_r;
      valid_nxt    = valid_r;
      start_nxt    = 1'b0;
      go           = 1'b0;
      go_seq       = 1'b0;
      go_chan      = cmd_chan_r;
      done_evt     = 1'b0;
      pick         = 4'h0;

      // Registers keep manual mode until the host writes a configuration
      if (i_cfg_write)
      begin
         mode_nxt     = op_mode_e'(i_op_mode);
         aux_nxt      = aux_mode_e'(i_aux_trigger_mode);
         rate_nxt     = i_rate;
         mask_nxt     = i_chan_mask;
         bdly_nxt     = i_bias_settle_delay;
         fdly_nxt     = i_filter_settle_delay;
         filt_n_nxt   = i_filt_count;
         gated_nxt    = i_touch_gated_interrupt;
         cfg_seen_nxt = 1'b1;
      end
      if (pwr_cnt_r != '0)
         pwr_cnt_nxt = pwr_cnt_r - PWR_W'(1);
      if (auto_mode && rate_cnt_r != '0)
         rate_cnt_nxt = rate_cnt_r - RCNT_W'(1);

      unique case (state_r)
         S_IDLE:
         begin
            if (oe_r)
            begin
               if (aux_r != AUX_OFF)
               begin
                  go     = aux_hit;
                  go_seq = (cmd_chan_r == SEQUENCE_CODE);
               end
               else if (mode_r == MODE_TOUCH_TRIG)
               begin
                  go     = touch_lvl;
                  go_seq = 1'b1;
               end
               else if (auto_mode && rate_cnt_r == '0)
               begin
                  // Touch detection opens every automatic cycle
                  rate_cnt_nxt = RCNT_W'(rate_r * RATE_CYCLES);
                  touched_nxt  = touch_lvl;
                  go           = touch_lvl || !gated_r;
                  go_seq       = 1'b1;
               end
               else if (mode_r == MODE_MANUAL_AUTO && !auto_mode && i_cmd_valid)
               begin
                  cmd_chan_nxt = i_cmd_chan;
                  go_chan      = i_cmd_chan;
                  go_seq       = (i_cmd_chan == SEQUENCE_CODE);
                  touched_nxt  = 1'b1;
                  go           = i_cmd_convert;
                  if (!i_cmd_convert && !go_seq)
                  begin
                     chan_nxt = i_cmd_chan;
                     bias_nxt = 1'b1;
                  end
               end
               if (mode_r == MODE_TOUCH_TRIG)
                  touched_nxt = 1'b1;
            end
            if (go)
            begin
               pick = pick_chan(mask_r, NUM_CH);
               if (!go_seq || pick[3])
               begin
                  chan_nxt     = go_seq ? pick[CHAN_W-1:0] : go_chan;
                  seq_nxt      = go_seq;
                  bias_nxt     = 1'b1;
                  dly_nxt      = bdly_r;
                  filt_cnt_nxt = '0;
                  state_nxt    = S_BIAS;
               end
            end
         end
         S_BIAS, S_FILT:
         begin
            if (dly_r == '0)
            begin
               start_nxt    = 1'b1;
               filt_cnt_nxt = filt_cnt_r + FILT_W'(1);
               state_nxt    = S_CONV;
            end
            else
               dly_nxt = dly_r - DLY_W'(1);
         end
         S_CONV:
         begin
            if (i_adc_done)
            begin
               pick = pick_chan(mask_r, int'(chan_r));
               if (filt_cnt_r < filt_eff)
               begin
                  dly_nxt   = fdly_r;
                  state_nxt = S_FILT;
               end
               else if (seq_r && pick[3])
               begin
                  chan_nxt     = pick[CHAN_W-1:0];
                  dly_nxt      = bdly_r;
                  filt_cnt_nxt = '0;
                  state_nxt    = S_BIAS;
               end
               else
               begin
                  // Bias drops as soon as the last conversion ends
                  bias_nxt  = 1'b0;
                  done_evt  = 1'b1;
                  state_nxt = S_IDLE;
               end
            end
         end
         default:
            state_nxt = S_IDLE;
      endcase

      // Set beats a clear arriving in the same cycle
      if (done_evt)
      begin
         conv_fl_nxt = 1'b1;
         valid_nxt   = touched_r;
      end
      else if (i_data_read_done)
         conv_fl_nxt = 1'b0;
      if (mode_r == MODE_TOUCH_DET && touch_rise)
         touch_fl_nxt = 1'b1;
      else if (i_status_read)
         touch_fl_nxt = 1'b0;
      if (i_status_read)
         rst_evt_nxt = 1'b0;
      oe_nxt = !((pwr_cnt_nxt != '0) || conv_fl_nxt || touch_fl_nxt);
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         state_r    <= S_IDLE;
         mode_r     <= MODE_MANUAL_AUTO;
         aux_r      <= AUX_OFF;
         rate_r     <= '0;
         mask_r     <= '0;
         bdly_r     <= '0;
         fdly_r     <= '0;
         filt_n_r   <= '0;
         gated_r    <= 1'b0;
         cfg_seen_r <= 1'b0;
         cmd_chan_r <= '0;
         chan_r     <= '0;
         seq_r      <= 1'b0;
         dly_r      <= '0;
         filt_cnt_r <= '0;
         rate_cnt_r <= '0;
         pwr_cnt_r  <= PWR_W'(POWERUP_CYCLES);
         touched_r  <= 1'b0;
         conv_fl_r  <= 1'b0;
         touch_fl_r <= 1'b0;
         rst_evt_r  <= RESET_EVT_RST;
         bias_r     <= 1'b0;
         start_r    <= 1'b0;
         valid_r    <= 1'b0;
         oe_r       <= 1'b0;
      end
      else if (i_ce)
      begin
         state_r    <= state_nxt;
         mode_r     <= mode_nxt;
         aux_r      <= aux_nxt;
         rate_r     <= rate_nxt;
         mask_r     <= mask_nxt;
         bdly_r     <= bdly_nxt;
         fdly_r     <= fdly_nxt;
         filt_n_r   <= filt_n_nxt;
         gated_r    <= gated_nxt;
         cfg_seen_r <= cfg_seen_nxt;
         cmd_chan_r <= cmd_chan_nxt;
         chan_r     <= chan_nxt;
         seq_r      <= seq_nxt;
         dly_r      <= dly_nxt;
         filt_cnt_r <= filt_cnt_nxt;
         rate_cnt_r <= rate_cnt_nxt;
         pwr_cnt_r  <= pwr_cnt_nxt;
         touched_r  <= touched_nxt;
         conv_fl_r  <= conv_fl_nxt;
         touch_fl_r <= touch_fl_nxt;
         rst_evt_r  <= rst_evt_nxt;
         bias_r     <= bias_nxt;
         start_r    <= start_nxt;
         valid_r    <= valid_nxt;
         oe_r       <= oe_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_host_alert_n_o  = 1'b0;
   assign o_host_alert_n_oe = oe_r;
   assign o_status          = {conv_fl_r, touch_fl_r, rst_evt_r, 5'h00};
   assign o_bias_en         = bias_r;
   assign o_conv_start      = start_r;
   assign o_conv_chan       = chan_r;
   assign o_data_valid      = valid_r;
   assign o_busy            = state_r != S_IDLE;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   sequence s_kick;
      i_ce && state_r == S_IDLE && go && (!go_seq || pick[3]);
   endsequence
   sequence s_finish;
      i_ce && done_evt;
   endsequence

   alert_powerup_a: assert property ((pwr_cnt_r != '0) |-> !o_host_alert_n_oe)
      else $error("alert released during power-up");
   alert_release_a: assert property ((pwr_cnt_r == '0 && !conv_fl_r && !touch_fl_r) |-> o_host_alert_n_oe)
      else $error("alert driven with no cause");
   touch_set_a: assert property (i_ce && mode_r == MODE_TOUCH_DET && touch_rise |=> o_status[6] && !o_host_alert_n_oe)
      else $error("touch did not raise flag and alert");
   touch_clear_a: assert property (i_ce && i_status_read && !(mode_r == MODE_TOUCH_DET && touch_rise) |=> !o_status[6])
      else $error("status read left touch flag set");
   done_alert_a: assert property (s_finish |=> o_status[7] && !o_host_alert_n_oe)
      else $error("completion did not raise flag and alert");
   done_clear_a: assert property (i_ce && i_data_read_done && !done_evt && !touch_fl_r && pwr_cnt_r == '0
                                  |=> !o_status[7] && o_host_alert_n_oe)
      else $error("data read left done flag or alert");
   no_start_alert_a: assert property (o_conv_start |-> o_host_alert_n_oe)
      else $error("conversion started with alert asserted");
   bias_first_a: assert property (s_kick |=> state_r == S_BIAS && o_bias_en && !o_conv_start)
      else $error("start did not enter bias settle");
   bias_hold_a: assert property (i_ce && state_r == S_BIAS && dly_r != '0 |=> !o_conv_start)
      else $error("conversion before bias delay ended");
   mask_order_a: assert property (o_conv_start && seq_r |-> mask_r[o_conv_chan])
      else $error("masked channel converted");
   filt_bound_a: assert property (state_r == S_CONV |-> filt_cnt_r != '0 && filt_cnt_r <= filt_eff)
      else $error("too many averaging conversions");
   manual_default_a: assert property (!cfg_seen_r |-> mode_r == MODE_MANUAL_AUTO && rate_r == '0)
      else $error("left manual mode without configuration");
   trig_wait_a: assert property (i_ce && state_r == S_IDLE && mode_r == MODE_TOUCH_TRIG && !touch_lvl
                                 |=> state_r == S_IDLE)
      else $error("touch-triggered start without touch");
endmodule

/* File: touch_seq_pkg.sv */
/*
 * Shared constants and types of the touch acquisition sequencer.
 * Assumes a 20 MHz sequencer clock; delay fields arrive already in clock cycles.
 */
package touch_seq_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int POWERUP_NS    = 100000;
   localparam int POWERUP_CYC   = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RATE_UNIT_NS  = 100000;
   localparam int RATE_UNIT_CYC = RATE_UNIT_NS / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Widths and codes
   // ----------------------------------------------------------------
   localparam int         NUM_CH        = 5;
   localparam int         CHAN_W        = 3;
   localparam int         DLY_W         = 16;
   localparam int         RATE_W        = 4;
   localparam int         FILT_W        = 3;
   localparam int         FILT_MAX      = 7;
   localparam logic [2:0] SEQUENCE_CODE = 3'h7;

   // ----------------------------------------------------------------
   // Status register layout and reset values
   // ----------------------------------------------------------------
   localparam int   STAT_CONV_BIT  = 7;
   localparam int   STAT_TOUCH_BIT = 6;
   localparam int   STAT_RESET_BIT = 5;
   localparam logic RESET_EVT_RST  = 1'b1;

   typedef enum logic [1:0] {
      MODE_MANUAL_AUTO = 2'h0,
      MODE_TOUCH_DET   = 2'h1,
      MODE_TOUCH_TRIG  = 2'h2
   } op_mode_e;

   typedef enum logic [1:0] {
      AUX_OFF  = 2'h0,
      AUX_RISE = 2'h1,
      AUX_FALL = 2'h2,
      AUX_BOTH = 2'h3
   } aux_mode_e;

   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_BIAS = 4'b0010,
      S_CONV = 4'b0100,
      S_FILT = 4'b1000
   } seq_state_e;
endpackage
